// ### src/ubg_uart.sv
// Serial port with baud-rate generator, divider and timer 1 source, APB slave
// How it works
// (RL1) Second byte received while first unread
// (RL2) 8/9 data bits, LSB first, full duplex
// (RL3) Mode 0 shifts at clock over two
// (RL4) Mode 2 rate clock/32 or /64
// (RL5) Modes 1,3 use baud timer or timer1
// (RL6) Prescaler, fractional divider, 8-bit reload timer
// (RL7) Timer clocked by divider or prescaler
// (RL8) Run bit starts timer in fractional mode
// (RL9) Underflow reloads and emits one pulse
// (RL10) Normal divider mode stops baud timer
// (RL11) Prescale divides by two to field
// (RL12) Rate is clock/16/prescale/(reload+1)
// (RL13) Software keeps prescale times reload above one
// (RL14) Timer1 auto-reload gives documented rate
// (RL15) Normal mode: 8-bit up-counter from step
// (RL16) Result shows counter, step is reload
// (RL17) Overflow sets flag and requests interrupt
// (RL18) Interrupt request on tx and rx done
// (RL19) Timer1 low byte reloads from high byte
// (RL20) Timer1 counts every two clocks
// (RL21) Start bit, data, stop bit, 16 ticks
`timescale 1ns/100ps
module ubg_uart
    import ubg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             div_irq
);
    ubg_apb_req_t req;
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    logic [6:0]  ctrl;
    logic [3:0]  baud_control_reg;
    logic [7:0]  baud_reload_reg;
    logic [1:0]  frac_div_control_reg;
    logic        normal_div_overflow_flag;
    logic [7:0]  frac_step_reg;
    logic [7:0]  frac_result_reg;
    logic [7:0]  timer1_high_reload_byte;
    logic [7:0]  t1_low;
    logic        t1_phase;
    logic [6:0]  pre_cnt;
    logic [7:0]  baud_cnt;
    logic [3:0]  tick16;
    logic [5:0]  m2_cnt;
    logic        m0_phase;
    logic        t1_ovf_half;
    logic        tx_done;
    logic        rx_done;
    logic        rb8;
    logic [7:0]  rx_buf;
    logic        rx_full;

    wire         setup_ok     = req.sel & ~req.enable;
    wire         access       = req.sel & req.enable;
    wire         hit_ctrl     = req.addr == UBG_CTRL_OFS;
    wire         hit_baud     = req.addr == UBG_BAUD_OFS;
    wire         hit_reload   = req.addr == UBG_RELOAD_OFS;
    wire         hit_fdctrl   = req.addr == UBG_FDCTRL_OFS;
    wire         hit_step     = req.addr == UBG_STEP_OFS;
    wire         hit_result   = req.addr == UBG_RESULT_OFS;
    wire         hit_txdata   = req.addr == UBG_TXDATA_OFS;
    wire         hit_rxdata   = req.addr == UBG_RXDATA_OFS;
    wire         hit_status   = req.addr == UBG_STATUS_OFS;
    wire         hit_t1       = req.addr == UBG_T1_OFS;
    wire         hit_any      = hit_ctrl | hit_baud | hit_reload | hit_fdctrl | hit_step | hit_result
                                | hit_txdata | hit_rxdata | hit_status | hit_t1;
    wire         wr           = access & pready & req.write;
    wire         rd           = access & pready & ~req.write;

    wire [1:0]   mode         = ctrl[UBG_MODE_LSB +: 2];
    wire         frac_div_enable      = frac_div_control_reg[UBG_FRAC_DIV_ENABLE_BIT];
    wire         frac_div_mode_select = frac_div_control_reg[UBG_FDM_BIT];
    wire         baud_run_bit         = baud_control_reg[UBG_RUN_BIT];
    wire [2:0]   baud_prescale_field  = baud_control_reg[UBG_PRE_LSB +: 3];

    // Prescaler: pulse every 2^field clocks
    wire [6:0]   pre_mask     = 7'((8'h01 << baud_prescale_field) - 8'h01);  // RL11
    wire         prescaler_output_clock = (pre_cnt & pre_mask) == pre_mask;  // RL6
    // Fractional divider accumulator carry, or normal-mode overflow
    wire [8:0]   frac_sum     = {1'b0, frac_result_reg} + {1'b0, frac_step_reg};
    wire [8:0]   norm_sum     = {1'b0, frac_result_reg} + 9'h001;
    wire         frac_mode_on = frac_div_enable & ~frac_div_mode_select;
    wire         norm_mode_on = frac_div_enable & frac_div_mode_select;
    wire         frac_divider_output_clock = prescaler_output_clock &
                                            (frac_mode_on ? frac_sum[8] : norm_sum[8]);
    wire         baud_in      = frac_div_enable ? frac_divider_output_clock : prescaler_output_clock;  // RL7
    wire         baud_active  = baud_run_bit & ~norm_mode_on;  // RL8 RL10
    wire         baud_uflow   = baud_active & baud_in & (baud_cnt == UBG_RESET_BYTE);  // RL9
    // Timer 1 in 8-bit auto-reload, machine cycle every two clocks
    wire         t1_tick      = ctrl[UBG_T1RUN_BIT] & t1_phase;  // RL20
    wire         t1_ovf       = t1_tick & (t1_low == 8'hff);
    wire         t1_rate      = t1_ovf & (ctrl[UBG_DOUBLE_SPEED_BIT_BIT] | t1_ovf_half);  // RL14
    wire         var_tick     = ctrl[UBG_SRC_T1_BIT] ? t1_rate : baud_uflow;  // RL5
    wire [5:0]   m2_last      = ctrl[UBG_DIV32_BIT] ? UBG_M2_DIV32_LAST : UBG_M2_DIV64_LAST;
    wire         m2_tick      = m2_cnt == m2_last;  // RL4
    // Sixteen-times oversampling tick for modes 1..3
    wire         os_tick      = (mode == 2'd2) ? m2_tick : var_tick;
    wire         bit_tick     = os_tick & (tick16 == UBG_TICKS_LAST);  // RL12 RL21
    wire         mode0_tick   = m0_phase;  // RL3

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt  <= 7'h00;
            baud_cnt <= 8'h00;
            t1_phase <= 1'b0;
            t1_low   <= 8'h00;
            t1_ovf_half <= 1'b0;
            m2_cnt   <= 6'h00;
            m0_phase <= 1'b0;
            tick16   <= 4'h0;
        end else begin
            pre_cnt  <= pre_cnt + 7'h01;
            t1_phase <= ~t1_phase;
            m0_phase <= ~m0_phase;
            m2_cnt   <= m2_tick ? 6'h00 : m2_cnt + 6'h01;
            if (os_tick) begin
                tick16 <= tick16 + 4'h1;
            end
            if (baud_active & baud_in) begin
                baud_cnt <= (baud_cnt == UBG_RESET_BYTE) ? baud_reload_reg : baud_cnt - 8'h01;  // RL9
            end
            if (t1_tick) begin
                t1_low <= t1_ovf ? timer1_high_reload_byte : t1_low + 8'h01;  // RL19
            end
            if (t1_ovf) begin
                t1_ovf_half <= ~t1_ovf_half;
            end
        end
    end

    // Transmitter
    ubg_tx_state_t tx_state;
    logic [8:0]    tx_shift;
    logic [3:0]    tx_bits;
    wire           tx_load  = wr & hit_txdata & (tx_state == UBG_TX_IDLE);
    wire           tx_step  = (mode == 2'd0) ? mode0_tick : bit_tick;
    wire [3:0]     nbits    = (mode == 2'd2 || mode == 2'd3) ? UBG_BITS9 : UBG_BITS8;  // RL2

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_state <= UBG_TX_IDLE;
            tx_shift <= 9'h000;
            tx_bits  <= 4'h0;
            txd      <= 1'b1;
            tx_done  <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            case (tx_state)
                UBG_TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift <= req.wdata[8:0];
                        tx_bits  <= 4'h0;
                        tx_state <= (mode == 2'd0) ? UBG_TX_DATA : UBG_TX_START;
                    end
                end
                UBG_TX_START: begin
                    if (tx_step) begin
                        txd      <= 1'b0;  // RL21
                        tx_state <= UBG_TX_DATA;
                    end
                end
                UBG_TX_DATA: begin
                    if (tx_step) begin
                        txd      <= tx_shift[0];  // RL2
                        tx_shift <= {1'b0, tx_shift[8:1]};
                        tx_bits  <= tx_bits + 4'h1;
                        if (tx_bits == nbits - 4'h1) begin
                            tx_state <= UBG_TX_STOP;
                        end
                    end
                end
                UBG_TX_STOP: begin
                    if (tx_step) begin
                        txd      <= 1'b1;
                        tx_done  <= 1'b1;  // RL18
                        tx_state <= UBG_TX_IDLE;
                    end
                end
                default: tx_state <= UBG_TX_IDLE;
            endcase
        end
    end

    // Receiver with one buffered byte beside the shifter
    ubg_rx_state_t rx_state;
    logic [8:0]    rx_shift;
    logic [3:0]    rx_bits;
    logic [3:0]    rx_os;
    logic          rxd_q;
    wire           ren      = ctrl[UBG_REN_BIT];
    wire           rx_clr   = rd & hit_rxdata;
    wire           rx_samp  = os_tick & (rx_os == UBG_TICKS_MID);
    wire           rx_end   = os_tick & (rx_os == UBG_TICKS_LAST);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_state <= UBG_RX_IDLE;
            rx_shift <= 9'h000;
            rx_bits  <= 4'h0;
            rx_os    <= 4'h0;
            rxd_q    <= 1'b1;
            rx_done  <= 1'b0;
            rx_buf   <= 8'h00;
            rb8      <= 1'b0;
            rx_full  <= 1'b0;
        end else begin
            rxd_q   <= rxd;
            rx_done <= 1'b0;
            if (rx_clr) begin
                rx_full <= 1'b0;
            end
            case (rx_state)
                UBG_RX_IDLE: begin
                    if (ren && mode != 2'd0 && rxd_q && !rxd) begin
                        rx_os    <= 4'h0;
                        rx_state <= UBG_RX_START;
                    end
                end
                UBG_RX_START: begin
                    if (os_tick) begin
                        rx_os <= rx_os + 4'h1;
                    end
                    if (rx_samp && rxd) begin
                        rx_state <= UBG_RX_IDLE;
                    end else if (rx_end) begin
                        rx_bits  <= 4'h0;
                        rx_state <= UBG_RX_DATA;
                    end
                end
                UBG_RX_DATA: begin
                    if (os_tick) begin
                        rx_os <= rx_os + 4'h1;
                    end
                    if (rx_samp) begin
                        rx_shift <= (nbits == UBG_BITS9) ? {rxd, rx_shift[8:1]} : {1'b0, rxd, rx_shift[7:1]};
                        rx_bits  <= rx_bits + 4'h1;
                    end
                    if (rx_end && rx_bits == nbits) begin
                        rx_state <= UBG_RX_STOP;
                    end
                end
                UBG_RX_STOP: begin
                    if (os_tick) begin
                        rx_os <= rx_os + 4'h1;
                    end
                    if (rx_samp) begin
                        // The newer byte overwrites an unread one
                        rx_buf   <= rx_shift[7:0];  // RL1
                        rb8      <= rx_shift[8];
                        rx_full  <= 1'b1;
                        rx_done  <= rxd;  // RL18
                        rx_state <= UBG_RX_IDLE;
                    end
                end
                default: rx_state <= UBG_RX_IDLE;
            endcase
        end
    end

    // Registers, divider counter and APB slave
    wire [31:0] rd_mux = hit_ctrl   ? {25'h0, ctrl} :
                         hit_baud   ? {28'h0, baud_control_reg} :
                         hit_reload ? {24'h0, baud_reload_reg} :
                         hit_fdctrl ? {29'h0, normal_div_overflow_flag, frac_div_control_reg} :
                         hit_step   ? {24'h0, frac_step_reg} :
                         hit_result ? {24'h0, frac_result_reg} :  // RL16
                         hit_rxdata ? {23'h0, rb8, rx_buf} :
                         hit_status ? {28'h0, rb8, tx_state != UBG_TX_IDLE, rx_full, 1'b0} :
                         hit_t1     ? {16'h0, t1_low, timer1_high_reload_byte} : 32'h0000_0000;
    wire        normal_div_overflow_flag_set = norm_mode_on & frac_divider_output_clock;  // RL17

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl                     <= 7'h00;
            baud_control_reg         <= 4'h0;
            baud_reload_reg          <= UBG_RESET_BYTE;
            frac_div_control_reg     <= 2'b00;
            normal_div_overflow_flag <= 1'b0;
            frac_step_reg            <= UBG_RESET_BYTE;
            frac_result_reg          <= UBG_RESET_BYTE;
            timer1_high_reload_byte  <= UBG_RESET_BYTE;
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;
            prdata                   <= 32'h0000_0000;
            tx_irq                   <= 1'b0;
            rx_irq                   <= 1'b0;
            div_irq                  <= 1'b0;
        end else begin
            pready  <= setup_ok;
            pslverr <= setup_ok & ~hit_any;
            prdata  <= setup_ok & ~req.write ? rd_mux : 32'h0000_0000;
            tx_irq  <= tx_done;  // RL18
            rx_irq  <= rx_done;
            div_irq <= normal_div_overflow_flag_set;  // RL17
            if (wr && hit_ctrl)   ctrl                 <= req.wdata[6:0];
            if (wr && hit_baud)   baud_control_reg     <= req.wdata[3:0];
            if (wr && hit_reload) baud_reload_reg      <= req.wdata[7:0];
            if (wr && hit_fdctrl) frac_div_control_reg <= req.wdata[1:0];
            if (wr && hit_step)   frac_step_reg        <= req.wdata[7:0];
            if (wr && hit_t1)     timer1_high_reload_byte <= req.wdata[7:0];
            if (normal_div_overflow_flag_set) begin
                normal_div_overflow_flag <= 1'b1;
            end else if (wr && hit_fdctrl && !req.wdata[UBG_NORMAL_DIV_OVERFLOW_FLAG_BIT]) begin
                normal_div_overflow_flag <= 1'b0;
            end
            if (wr && hit_result) begin
                frac_result_reg <= req.wdata[7:0];
            end else if (frac_div_enable && prescaler_output_clock) begin
                frac_result_reg <= frac_mode_on ? frac_sum[7:0] :
                                   (norm_sum[8] ? frac_step_reg : norm_sum[7:0]);  // RL15
            end
        end
    end
endmodule : ubg_uart

// ### src/ubg_pkg.sv
// Package for the serial port with baud-rate generator
package ubg_pkg;
    localparam logic [31:0] UBG_CTRL_OFS     = 32'h0000_0000;
    localparam logic [31:0] UBG_BAUD_OFS     = 32'h0000_0004;
    localparam logic [31:0] UBG_RELOAD_OFS   = 32'h0000_0008;
    localparam logic [31:0] UBG_FDCTRL_OFS   = 32'h0000_000c;
    localparam logic [31:0] UBG_STEP_OFS     = 32'h0000_0010;
    localparam logic [31:0] UBG_RESULT_OFS   = 32'h0000_0014;
    localparam logic [31:0] UBG_TXDATA_OFS   = 32'h0000_0018;
    localparam logic [31:0] UBG_RXDATA_OFS   = 32'h0000_001c;
    localparam logic [31:0] UBG_STATUS_OFS   = 32'h0000_0020;
    localparam logic [31:0] UBG_T1_OFS       = 32'h0000_0024;
    // Control register fields
    localparam int          UBG_MODE_LSB     = 0;
    localparam int          UBG_REN_BIT      = 2;
    localparam int          UBG_DIV32_BIT    = 3;
    localparam int          UBG_SRC_T1_BIT   = 4;
    localparam int          UBG_DOUBLE_SPEED_BIT_BIT     = 5;
    localparam int          UBG_T1RUN_BIT    = 6;
    // Baud control fields
    localparam int          UBG_RUN_BIT      = 0;
    localparam int          UBG_PRE_LSB      = 1;
    // Fractional divider control fields
    localparam int          UBG_FRAC_DIV_ENABLE_BIT     = 0;
    localparam int          UBG_FDM_BIT      = 1;
    localparam int          UBG_NORMAL_DIV_OVERFLOW_FLAG_BIT     = 2;
    // Status fields
    localparam int          UBG_TXDONE_BIT   = 0;
    localparam int          UBG_RXDONE_BIT   = 1;
    localparam int          UBG_TXBUSY_BIT   = 2;
    localparam int          UBG_RB8_BIT      = 3;
    localparam logic [7:0]  UBG_RESET_BYTE   = 8'h00;
    localparam logic [3:0]  UBG_TICKS_LAST   = 4'hf;
    localparam logic [3:0]  UBG_TICKS_MID    = 4'h7;
    // Mode 2 oversampling tick every 4 or 2 clocks, so one bit lasts 64 or 32 clocks
    localparam logic [5:0]  UBG_M2_DIV64_LAST = 6'h03;
    localparam logic [5:0]  UBG_M2_DIV32_LAST = 6'h01;
    localparam logic [3:0]  UBG_BITS8        = 4'h8;
    localparam logic [3:0]  UBG_BITS9        = 4'h9;
    typedef enum logic [3:0] {
        UBG_TX_IDLE  = 4'b0001,
        UBG_TX_START = 4'b0010,
        UBG_TX_DATA  = 4'b0100,
        UBG_TX_STOP  = 4'b1000
    } ubg_tx_state_t;
    typedef enum logic [3:0] {
        UBG_RX_IDLE  = 4'b0001,
        UBG_RX_START = 4'b0010,
        UBG_RX_DATA  = 4'b0100,
        UBG_RX_STOP  = 4'b1000
    } ubg_rx_state_t;
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ubg_apb_req_t;
endpackage : ubg_pkg

// ### bench/ubg_uart_assertions.sv
// Checker for the serial port block, bound to its top module
`timescale 1ns/100ps
module ubg_uart_checker (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        tx_irq,
    input wire logic        rx_irq,
    input wire logic        div_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_ready_access: assert property (psel && !penable |=> pready)
        else $error("no answer in the access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("answer held longer than one cycle");
    a_ready_cause: assert property (pready |-> psel && penable)
        else $error("answer outside an access cycle");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data driven without an answer");
    a_err_paired: assert property (pslverr |-> pready)
        else $error("error flag without an answer");
    a_unmapped_err: assert property (psel && !penable && paddr > 32'h24 |=> pslverr && prdata == 32'h0)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (psel && !penable && paddr <= 32'h24 && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped address refused");
    a_tx_stop_high: assert property (tx_irq |-> txd)
        else $error("frame done while line is not at stop level");
    a_tx_done_pulse: assert property (tx_irq |=> !tx_irq)
        else $error("transmit event longer than one cycle");
    a_rx_done_pulse: assert property (rx_irq |=> !rx_irq)
        else $error("receive event longer than one cycle");
endmodule : ubg_uart_checker
bind ubg_uart ubg_uart_checker ubg_uart_checker_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq), .div_irq(div_irq));

// ### bench/ubg_serial_peer.sv
// Remote asynchronous transceiver on the transmit and receive lines
`timescale 1ns/100ps
module ubg_serial_peer (
    input  wire logic clock,
    input  wire logic txd,
    output logic      rxd
);
    int         bit_clks = 32;
    int         nbits    = 8;
    int         got_cnt  = 0;
    logic [8:0] got;
    logic       stop_ok;
    // Line is pulled up, so it idles high between frames
    initial rxd = 1'b1;
    // Samples every data bit and the stop bit in its middle
    always begin
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge clock);
        got = 9'h0;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge clock);
            got[i] = txd;
        end
        repeat (bit_clks) @(posedge clock);
        stop_ok = txd;
        got_cnt++;
    end
    task automatic send(input logic [8:0] d);
        rxd <= 1'b0;
        repeat (bit_clks) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            rxd <= d[i];
            repeat (bit_clks) @(posedge clock);
        end
        rxd <= 1'b1;
        repeat (bit_clks) @(posedge clock);
    endtask : send
endmodule : ubg_serial_peer

// ### bench/ubg_uart_tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module ubg_uart_tb
    import ubg_pkg::*;
;
    localparam int LIM = 4000;
    logic        clock   = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = 32'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, rxd, txd, tx_irq, rx_irq, div_irq;
    int          mismatches = 0, compares = 0, tx_cnt = 0, rx_cnt = 0;
    int          cyc = 0, div_last = 0, div_gap = 0;
    ubg_uart ubg_uart_inst (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq), .div_irq(div_irq));
    ubg_serial_peer peer_inst (.clock(clock), .txd(txd), .rxd(rxd));
    initial forever #4 clock = ~clock;
    // Event counters and the spacing of divider overflows
    always @(posedge clock) begin
        cyc++;
        if (tx_irq === 1'b1) tx_cnt++;
        if (rx_irq === 1'b1) rx_cnt++;
        if (div_irq === 1'b1) begin
            div_gap  = cyc - div_last;
            div_last = cyc;
        end
    end
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic tmo(input logic hit);
        if (hit) begin
            $display("[FAIL] wait bound reached");
            mismatches++;
            complete_run();
        end
    endtask : tmo
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        tmo(n >= 16);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic chk_rd(input logic [31:0] a, m, ex);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK($sformatf("register %h", a), ex, r & m)
    endtask : chk_rd
    // Counts clocks until the transmit line reaches the given level
    task automatic wait_txd(input logic lvl, output int n);
        n = 0;
        while (txd !== lvl && n < LIM) begin
            @(posedge clock);
            n++;
        end
        tmo(n >= LIM);
    endtask : wait_txd
    task automatic tx_frame(input logic [31:0] c, input int bc, nb, input logic [8:0] d);
        int n, base, tbase;
        base  = peer_inst.got_cnt;
        tbase = tx_cnt;
        peer_inst.bit_clks = bc;
        peer_inst.nbits    = nb;
        wr(UBG_CTRL_OFS, c);
        wr(UBG_TXDATA_OFS, {23'h0, d});
        wait_txd(1'b0, n);
        wait_txd(1'b1, n);
        `CHK("start bit clocks", bc, n)
        n = 0;
        while (peer_inst.got_cnt == base && n < LIM * 4) begin
            @(posedge clock);
            n++;
        end
        tmo(n >= LIM * 4);
        `CHK("frame bits", d, peer_inst.got)
        `CHK("stop level", 1'b1, peer_inst.stop_ok)
        repeat (bc) @(posedge clock);
        `CHK("transmit events", tbase + 1, tx_cnt)
    endtask : tx_frame
    initial begin
        logic [31:0] r;
        logic        e;
        repeat (2) @(posedge clock);
        `CHK("line level in reset", 1'b1, txd)
        reset_n <= 1'b1;
        chk_rd(UBG_STATUS_OFS, 32'hffff_ffff, 32'h0);
        apb(1'b0, 32'h40, 32'h0, r, e);
        `CHK("unmapped refusal", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        wr(UBG_RELOAD_OFS, 32'h1ff);
        chk_rd(UBG_RELOAD_OFS, 32'hffff_ffff, 32'hff);
        wr(UBG_RELOAD_OFS, 32'h1);
        for (int p = 0; p < 3; p++) begin
            wr(UBG_BAUD_OFS, 32'(p * 2 + 1));
            tx_frame(32'h5, 32 << p, 8, 9'h0a5 ^ 9'(p * 2));
        end
        wr(UBG_BAUD_OFS, 32'h1);
        peer_inst.bit_clks = 32;
        fork
            begin
                peer_inst.send(9'h03c);
                peer_inst.send(9'h0c3);
            end
            tx_frame(32'h5, 32, 8, 9'h081);
        join
        `CHK("receive events", 2, rx_cnt)
        chk_rd(UBG_STATUS_OFS, 32'h2, 32'h2);
        chk_rd(UBG_RXDATA_OFS, 32'hff, 32'hc3);
        chk_rd(UBG_STATUS_OFS, 32'h2, 32'h0);
        wr(UBG_STEP_OFS, 32'h80);
        wr(UBG_FDCTRL_OFS, 32'h1);
        tx_frame(32'h5, 64, 8, 9'h0a7);
        wr(UBG_BAUD_OFS, 32'h3);
        wr(UBG_STEP_OFS, 32'hfa);
        wr(UBG_FDCTRL_OFS, 32'h3);
        wr(UBG_TXDATA_OFS, 32'h55);
        repeat (800) @(posedge clock);
        chk_rd(UBG_STATUS_OFS, 32'h4, 32'h4);
        `CHK("divider overflow spacing", 12, div_gap)
        chk_rd(UBG_FDCTRL_OFS, 32'h7, 32'h7);
        chk_rd(UBG_STEP_OFS, 32'hff, 32'hfa);
        wr(UBG_FDCTRL_OFS, 32'h0);
        // An overflow in the cycle of the first write wins over its clear
        wr(UBG_FDCTRL_OFS, 32'h0);
        chk_rd(UBG_FDCTRL_OFS, 32'h7, 32'h0);
        repeat (1400) @(posedge clock);
        chk_rd(UBG_STATUS_OFS, 32'h4, 32'h0);
        tx_frame(32'h0a, 32, 9, 9'h1a5);
        tx_frame(32'h02, 64, 9, 9'h0b3);
        wr(UBG_T1_OFS, 32'hfe);
        tx_frame(32'h73, 64, 9, 9'h16d);
        tx_frame(32'h53, 128, 9, 9'h0c5);
        // Shift register mode finishes eight bits at two clocks each
        r = 32'(tx_cnt);
        wr(UBG_CTRL_OFS, 32'h0);
        wr(UBG_TXDATA_OFS, 32'h5a);
        repeat (24) @(posedge clock);
        `CHK("shift register events", r + 32'h1, 32'(tx_cnt))
        complete_run();
    end
endmodule : ubg_uart_tb
